/* File: design/tme_pkg.sv */
// constants, register map and types of the timestamp modulo event block
package tme_pkg;
    // time base
    localparam int unsigned CLK_NS        = 10;
    localparam int unsigned TICK_LOCAL_NS = 1000;
    localparam int unsigned TICK_PTP_NS   = 8;
    localparam int unsigned US_CYC        =
        (TICK_LOCAL_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ELECT_MS      = 2000;
    localparam int unsigned ELECT_CYC     = ELECT_MS * (1000000 / CLK_NS);

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CMD      = 8'h04;
    localparam logic [7:0] OFS_PERIOD   = 8'h08;
    localparam logic [7:0] OFS_START_LO = 8'h10;
    localparam logic [7:0] OFS_START_HI = 8'h14;
    localparam logic [7:0] OFS_EFF_LO   = 8'h18;
    localparam logic [7:0] OFS_EFF_HI   = 8'h1c;
    localparam logic [7:0] OFS_CAP_LO   = 8'h20;
    localparam logic [7:0] OFS_CAP_HI   = 8'h24;
    localparam logic [7:0] OFS_STATUS   = 8'h28;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h2c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h30;

    // field positions
    localparam int unsigned CMD_CLEAR_BIT   = 0;
    localparam int unsigned CMD_CAPTURE_BIT = 1;
    localparam int unsigned IRQ_EVT_BIT     = 0;
    localparam int unsigned IRQ_ELECT_BIT   = 1;

    // reset values
    localparam logic [4:0]  CTRL_RST   = 5'h00;
    localparam logic [31:0] PERIOD_RST = 32'h0000_0000;
    localparam logic [63:0] START_RST  = 64'h0;
    localparam logic [1:0]  MASK_RST   = 2'h0;

    // inserted in the middle of the hardware address
    localparam logic [15:0] EUI_FILL = 16'hfffe;

    // control register layout, bit 0 is sync_mode
    typedef struct packed {
        logic force_master;
        logic manual_role;
        logic trig_sel;
        logic run;
        logic net_time_sync_mode;
    } tme_ctrl_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_CALC = 4'b0010,
        S_WAIT = 4'b0100,
        S_RUN  = 4'b1000
    } tme_sched_t;

    typedef enum logic [2:0] {
        E_OFF  = 3'b001,
        E_AUTO = 3'b010,
        E_DONE = 3'b100
    } tme_elect_t;
endpackage : tme_pkg

/* File: design/tme_timestamp_modulo.sv */
// timestamp counter, modulo event scheduler and master election
// Function
// - without network sync the local counter counts one per microsecond.
// - with network sync the event timestamp is the 8 ns precision counter.
// - clear zeroes the active count only without sync; else local only.
// - sync on selects the precision source; its count cannot be cleared.
// - first event at first period multiple after the requested start.
// - after the first event, repeat every period until run stops.
// - start just before a multiple may fire there or one period later.
// - clear before the first event keeps the effective start unchanged.
// - clear while running restarts events at multiples of the new count.
// - period may change while running; next is previous plus new period.
// - clock identity is the hardware address with fffe in the middle.
// - in auto election the lowest hardware address becomes master.
// - roles form automatically, or software assigns master or slave.
// - automatic election window is about two seconds.
// - the modulo event may be chosen as acquisition trigger source.
// - a start already past is moved forward by whole periods and shown.
// - 64-bit count is read through a capture command into a field.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
module tme_timestamp_modulo #(
    parameter int unsigned ELECT_CYC = tme_pkg::ELECT_CYC
) (
    // clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        RESETN_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // network time and identity
    input  wire logic [63:0] PTP_TIME_I,
    input  wire logic [47:0] MAC_ADDR_I,
    input  wire logic        PEER_VALID_I,
    input  wire logic [47:0] PEER_MAC_I,
    // results
    output logic      [63:0] CLOCK_ID_O,
    output logic      [63:0] MASTER_ID_O,
    output logic             IS_MASTER_O,
    output logic             EVENT_O,
    output logic             TRIG_O,
    output logic             IRQ_O
);
    function automatic logic [63:0] eui(input logic [47:0] mac);
        eui = {mac[47:24], tme_pkg::EUI_FILL, mac[23:0]};
    endfunction : eui

    tme_pkg::tme_ctrl_t  ctrl_reg,   ctrl_next;
    logic [31:0]         period_reg, period_next;
    logic [63:0]         start_reg,  start_next;
    logic [63:0]         cap_reg,    cap_next;
    logic [63:0]         lcnt_reg,   lcnt_next;
    logic [6:0]          div_reg,    div_next;
    logic [1:0]          mask_reg,   mask_next;
    logic [1:0]          stat_reg,   stat_next;
    logic [31:0]         rdata_reg,  rdata_next;
    logic                err_reg,    err_next;
    tme_pkg::tme_sched_t st_reg,     st_next;
    logic [63:0]         base_reg,   base_next;
    logic [63:0]         opnd_reg,   opnd_next;
    logic [63:0]         rem_reg,    rem_next;
    logic [5:0]          cnt_reg,    cnt_next;
    logic [63:0]         eff_reg,    eff_next;
    logic [63:0]         last_reg,   last_next;
    logic                evt_reg,    trig_reg;
    tme_pkg::tme_elect_t est_reg,    est_next;
    logic                mst_reg,    mst_next;
    logic [31:0]         tmr_reg,    tmr_next;
    logic [47:0]         best_reg,   best_next;
    logic [63:0]         cid_reg,    mid_reg;
    logic                wr;
    logic                setup;
    logic                cmd_clear;
    logic                cmd_cap;
    logic                us_en;
    logic                ts_clear;
    logic [63:0]         ts;
    logic [63:0]         period64;
    logic [63:0]         rem_t;
    logic                hit;
    logic                done;
    logic                map_ok;
    logic [31:0]         rdata_c;

    // bus strobes; a write lands only in the access phase
    assign wr        = PSEL_I & PENABLE_I & PWRITE_I;
    assign setup     = PSEL_I & ~PENABLE_I;
    assign cmd_clear = wr & (PADDR_I == tme_pkg::OFS_CMD)
                     & PWDATA_I[tme_pkg::CMD_CLEAR_BIT];
    assign cmd_cap   = wr & (PADDR_I == tme_pkg::OFS_CMD)
                     & PWDATA_I[tme_pkg::CMD_CAPTURE_BIT];
    assign us_en     = (div_reg == 7'(tme_pkg::US_CYC - 1));
    // source follows sync mode, no separate select to get wrong
    assign ts        = ctrl_reg.net_time_sync_mode ? PTP_TIME_I
                                                   : lcnt_reg;
    // the precision count lives outside and has no clear input
    assign ts_clear  = cmd_clear & ~ctrl_reg.net_time_sync_mode;
    assign period64  = {32'h0, period_reg};

    // read decode
    always_comb begin
        map_ok  = 1'b1;
        rdata_c = 32'h0;
        if (PADDR_I == tme_pkg::OFS_CTRL) begin
            rdata_c = {27'h0, ctrl_reg};
        end else if (PADDR_I == tme_pkg::OFS_CMD) begin
            rdata_c = 32'h0;
        end else if (PADDR_I == tme_pkg::OFS_PERIOD) begin
            rdata_c = period_reg;
        end else if (PADDR_I == tme_pkg::OFS_START_LO) begin
            rdata_c = start_reg[31:0];
        end else if (PADDR_I == tme_pkg::OFS_START_HI) begin
            rdata_c = start_reg[63:32];
        end else if (PADDR_I == tme_pkg::OFS_EFF_LO) begin
            rdata_c = eff_reg[31:0];
        end else if (PADDR_I == tme_pkg::OFS_EFF_HI) begin
            rdata_c = eff_reg[63:32];
        end else if (PADDR_I == tme_pkg::OFS_CAP_LO) begin
            rdata_c = cap_reg[31:0];
        end else if (PADDR_I == tme_pkg::OFS_CAP_HI) begin
            rdata_c = cap_reg[63:32];
        end else if (PADDR_I == tme_pkg::OFS_STATUS) begin
            rdata_c = {27'h0, st_reg == tme_pkg::S_RUN,
                       st_reg == tme_pkg::S_WAIT,
                       est_reg == tme_pkg::E_DONE, mst_reg,
                       ctrl_reg.net_time_sync_mode};
        end else if (PADDR_I == tme_pkg::OFS_IRQ_STAT) begin
            rdata_c = {30'h0, stat_reg};
        end else if (PADDR_I == tme_pkg::OFS_IRQ_MASK) begin
            rdata_c = {30'h0, mask_reg};
        end else begin
            map_ok  = 1'b0;
        end
    end

    // register file, local counter and capture
    always_comb begin
        ctrl_next   = ctrl_reg;
        period_next = period_reg;
        start_next  = start_reg;
        mask_next   = mask_reg;
        cap_next    = cap_reg;
        rdata_next  = rdata_reg;
        err_next    = err_reg;
        div_next    = us_en ? 7'h00 : div_reg + 7'h01;
        lcnt_next   = us_en ? lcnt_reg + 64'h1 : lcnt_reg;
        if (cmd_clear) begin
            div_next  = 7'h00;
            lcnt_next = 64'h0;
        end
        if (cmd_cap) begin
            cap_next = ts;
        end
        // answer prepared in setup so read data comes from a flop
        if (setup) begin
            rdata_next = PWRITE_I ? 32'h0 : rdata_c;
            err_next   = ~map_ok;
        end
        if (wr) begin
            if (PADDR_I == tme_pkg::OFS_CTRL) begin
                ctrl_next = tme_pkg::tme_ctrl_t'(PWDATA_I[4:0]);
            end else if (PADDR_I == tme_pkg::OFS_PERIOD) begin
                period_next = PWDATA_I;
            end else if (PADDR_I == tme_pkg::OFS_START_LO) begin
                start_next[31:0] = PWDATA_I;
            end else if (PADDR_I == tme_pkg::OFS_START_HI) begin
                start_next[63:32] = PWDATA_I;
            end else if (PADDR_I == tme_pkg::OFS_IRQ_MASK) begin
                mask_next = PWDATA_I[1:0];
            end
        end
        // a new event beats a write-one clear in the same cycle
        stat_next = stat_reg;
        if (wr && PADDR_I == tme_pkg::OFS_IRQ_STAT) begin
            stat_next = stat_reg & ~PWDATA_I[1:0];
        end
        stat_next[tme_pkg::IRQ_EVT_BIT]   = stat_next[0] | hit;
        stat_next[tme_pkg::IRQ_ELECT_BIT] = stat_next[1] | done;
    end

    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctrl_reg   <= tme_pkg::CTRL_RST;
            period_reg <= tme_pkg::PERIOD_RST;
            start_reg  <= tme_pkg::START_RST;
            mask_reg   <= tme_pkg::MASK_RST;
            stat_reg   <= 2'h0;
            cap_reg    <= 64'h0;
            lcnt_reg   <= 64'h0;
            div_reg    <= 7'h00;
            rdata_reg  <= 32'h0;
            err_reg    <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            period_reg <= period_next;
            start_reg  <= start_next;
            mask_reg   <= mask_next;
            stat_reg   <= stat_next;
            cap_reg    <= cap_next;
            lcnt_reg   <= lcnt_next;
            div_reg    <= div_next;
            rdata_reg  <= rdata_next;
            err_reg    <= err_next;
        end
    end

    // scheduler: a 64-step serial remainder avoids a wide divider
    always_comb begin
        st_next   = st_reg;
        base_next = base_reg;
        opnd_next = opnd_reg;
        rem_next  = rem_reg;
        cnt_next  = cnt_reg;
        eff_next  = eff_reg;
        last_next = last_reg;
        hit       = 1'b0;
        rem_t     = {rem_reg[62:0], opnd_reg[63]};
        if (rem_t >= period64) begin
            rem_t = rem_t - period64;
        end
        case (st_reg)
            tme_pkg::S_IDLE: begin
                if (ctrl_reg.run && period_reg != 32'h0) begin
                    // a past start is pushed forward past now
                    base_next = (start_reg > ts) ? start_reg : ts;
                    opnd_next = base_next;
                    rem_next  = 64'h0;
                    cnt_next  = 6'h00;
                    st_next   = tme_pkg::S_CALC;
                end
            end
            tme_pkg::S_CALC: begin
                rem_next  = rem_t;
                opnd_next = {opnd_reg[62:0], 1'b0};
                cnt_next  = cnt_reg + 6'h01;
                if (cnt_reg == 6'h3f) begin
                    eff_next = base_reg - rem_t + period64;
                    st_next  = tme_pkg::S_WAIT;
                end
            end
            tme_pkg::S_WAIT: begin
                // a clear here leaves the effective start alone
                if (ts >= eff_reg) begin
                    hit       = 1'b1;
                    last_next = eff_reg;
                    st_next   = tme_pkg::S_RUN;
                end
            end
            tme_pkg::S_RUN: begin
                if (ts_clear) begin
                    last_next = 64'h0;
                end else if (period_reg != 32'h0 &&
                             ts >= last_reg + period64) begin
                    hit       = 1'b1;
                    last_next = last_reg + period64;
                end
            end
            default: begin
                st_next = tme_pkg::S_IDLE;
            end
        endcase
        if (!ctrl_reg.run) begin
            st_next = tme_pkg::S_IDLE;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st_reg   <= tme_pkg::S_IDLE;
            base_reg <= 64'h0;
            opnd_reg <= 64'h0;
            rem_reg  <= 64'h0;
            cnt_reg  <= 6'h00;
            eff_reg  <= 64'h0;
            last_reg <= 64'h0;
            evt_reg  <= 1'b0;
            trig_reg <= 1'b0;
        end else begin
            st_reg   <= st_next;
            base_reg <= base_next;
            opnd_reg <= opnd_next;
            rem_reg  <= rem_next;
            cnt_reg  <= cnt_next;
            eff_reg  <= eff_next;
            last_reg <= last_next;
            evt_reg  <= hit;
            trig_reg <= hit & ctrl_reg.trig_sel;
        end
    end

    // election; peers report their address when they announce
    always_comb begin
        est_next  = est_reg;
        mst_next  = mst_reg;
        tmr_next  = tmr_reg;
        best_next = best_reg;
        done      = 1'b0;
        case (est_reg)
            tme_pkg::E_OFF: begin
                if (ctrl_reg.net_time_sync_mode) begin
                    best_next = MAC_ADDR_I;
                    tmr_next  = 32'h0;
                    if (ctrl_reg.manual_role) begin
                        mst_next = ctrl_reg.force_master;
                        est_next = tme_pkg::E_DONE;
                        done     = 1'b1;
                    end else begin
                        mst_next = 1'b1;
                        est_next = tme_pkg::E_AUTO;
                    end
                end
            end
            tme_pkg::E_AUTO: begin
                tmr_next = tmr_reg + 32'h1;
                if (PEER_VALID_I && PEER_MAC_I < best_reg) begin
                    best_next = PEER_MAC_I;
                    mst_next  = 1'b0;
                end
                if (tmr_reg == 32'(ELECT_CYC - 1)) begin
                    est_next = tme_pkg::E_DONE;
                    done     = 1'b1;
                end
            end
            tme_pkg::E_DONE: begin
                if (ctrl_reg.manual_role) begin
                    mst_next = ctrl_reg.force_master;
                    if (PEER_VALID_I && !ctrl_reg.force_master) begin
                        best_next = PEER_MAC_I;
                    end
                end else if (PEER_VALID_I && PEER_MAC_I < best_reg) begin
                    best_next = PEER_MAC_I;
                    mst_next  = 1'b0;
                end
            end
            default: begin
                est_next = tme_pkg::E_OFF;
            end
        endcase
        if (!ctrl_reg.net_time_sync_mode) begin
            est_next = tme_pkg::E_OFF;
            mst_next = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            est_reg  <= tme_pkg::E_OFF;
            mst_reg  <= 1'b0;
            tmr_reg  <= 32'h0;
            best_reg <= 48'h0;
            cid_reg  <= 64'h0;
            mid_reg  <= 64'h0;
        end else begin
            est_reg  <= est_next;
            mst_reg  <= mst_next;
            tmr_reg  <= tmr_next;
            best_reg <= best_next;
            cid_reg  <= eui(MAC_ADDR_I);
            mid_reg  <= eui(best_next);
        end
    end

    // outputs
    assign PRDATA_O    = rdata_reg;
    assign PREADY_O    = 1'b1;
    assign PSLVERR_O   = err_reg;
    assign CLOCK_ID_O  = cid_reg;
    assign MASTER_ID_O = mid_reg;
    assign IS_MASTER_O = mst_reg;
    assign EVENT_O     = evt_reg;
    assign TRIG_O      = trig_reg;
    assign IRQ_O       = |(stat_reg & mask_reg);

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESETN_I);

    property p_us_gap;
        us_en |=> (!us_en) [*8];
    endproperty
    a_us_gap: assert property (p_us_gap)
        else $error("local tick enable too frequent");

    property p_cap_src;
        ctrl_reg.net_time_sync_mode && cmd_cap |=>
            cap_reg == $past(PTP_TIME_I);
    endproperty
    a_cap_src: assert property (p_cap_src)
        else $error("capture did not take precision time");

    property p_clear;
        cmd_clear |=> lcnt_reg == 64'h0 && div_reg == 7'h00;
    endproperty
    a_clear: assert property (p_clear)
        else $error("local counter not cleared");

    property p_sync_keep;
        ctrl_reg.net_time_sync_mode && cmd_clear &&
            st_reg == tme_pkg::S_RUN && !hit |=> last_reg == $past(last_reg);
    endproperty
    a_sync_keep: assert property (p_sync_keep)
        else $error("clear disturbed events under sync");

    property p_first;
        st_reg == tme_pkg::S_CALC && cnt_reg == 6'h3f |=>
            eff_reg > $past(base_reg) &&
            eff_reg <= $past(base_reg) + $past(period64);
    endproperty
    a_first: assert property (p_first)
        else $error("effective start not next multiple");

    property p_step;
        st_reg == tme_pkg::S_RUN && hit |=>
            last_reg == $past(last_reg) + $past(period64);
    endproperty
    a_step: assert property (p_step)
        else $error("event not one period after previous");

    property p_keep_eff;
        st_reg == tme_pkg::S_WAIT && ts_clear |=> eff_reg == $past(eff_reg);
    endproperty
    a_keep_eff: assert property (p_keep_eff)
        else $error("effective start changed by clear");

    property p_restart;
        st_reg == tme_pkg::S_RUN && ts_clear && ctrl_reg.run |=>
            last_reg == 64'h0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("schedule not restarted after clear");

    property p_pulse;
        hit |=> EVENT_O ##1 !EVENT_O;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("event not a single pulse");

    property p_trig;
        TRIG_O |-> EVENT_O && $past(ctrl_reg.trig_sel);
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger without selected event");

    property p_elect;
        est_reg == tme_pkg::E_AUTO && PEER_VALID_I &&
            PEER_MAC_I < best_reg && ctrl_reg.net_time_sync_mode
            |=> !IS_MASTER_O;
    endproperty
    a_elect: assert property (p_elect)
        else $error("lower peer did not win election");

    property p_window;
        est_reg == tme_pkg::E_AUTO |-> tmr_reg < ELECT_CYC;
    endproperty
    a_window: assert property (p_window)
        else $error("election window overran");

    // the identity register loads one edge after reset is released
    property p_cid;
        RESETN_I |=> CLOCK_ID_O == eui($past(MAC_ADDR_I));
    endproperty
    a_cid: assert property (p_cid)
        else $error("clock identity malformed");
endmodule : tme_timestamp_modulo

/* File: verification/tme_peer_model.sv */
// peer clock model: precision time source and peer address announcer
module tme_peer_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // precision time and peer announcements
    output logic      [63:0] ptp_time_o,
    output logic             peer_valid_o,
    output logic      [47:0] peer_mac_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // one tick per clock, a scaled stand-in so runs stay short
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) ptp_time_o <= 64'h0;
        else ptp_time_o <= ptp_time_o + 64'h1;
    end

    initial begin
        peer_valid_o = 1'b0;
        peer_mac_o = 48'h0;
    end

    // address shows its inverse once released, so stale data never matches
    task announce(input logic [47:0] mac);
        @(posedge clk_i);
        peer_valid_o <= 1'b1;
        peer_mac_o <= mac;
        @(posedge clk_i);
        peer_valid_o <= 1'b0;
        peer_mac_o <= ~mac;
    endtask : announce
endmodule : tme_peer_model

/* File: verification/tme_timestamp_modulo_tb.sv */
// self-checking bench for the timestamp modulo event block
module tme_timestamp_modulo_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [47:0] MAC = 48'h0a1b2c3d4e5f; // arbitrary address
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, pv, is_m, evt, trig, irq;
    logic [47:0] pmac;
    logic [63:0] ptp, cid, mid, t1, t2, t3;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cyc = 0;

    tme_timestamp_modulo #(.ELECT_CYC(50)) uut (
        .REF_CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .PTP_TIME_I(ptp), .MAC_ADDR_I(MAC),
        .PEER_VALID_I(pv), .PEER_MAC_I(pmac), .CLOCK_ID_O(cid),
        .MASTER_ID_O(mid), .IS_MASTER_O(is_m), .EVENT_O(evt),
        .TRIG_O(trig), .IRQ_O(irq));

    tme_peer_model peer (.clk_i(clk), .rst_n_i(rst_n), .ptp_time_o(ptp),
        .peer_valid_o(pv), .peer_mac_o(pmac));

    always #5 clk = ~clk;

    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    task conclude;
        $display("mismatches %0d checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task chk(input string what, input logic [63:0] exp, logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    function automatic logic [63:0] eui(input logic [47:0] m);
        return {m[47:24], 16'hfffe, m[23:0]};
    endfunction : eui

    // one apb transfer; waits for pready, never assumes a latency
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    // sampled on the falling edge, where the pulse has settled
    task wev(output logic [63:0] p);
        do @(negedge clk); while (evt !== 1'b1);
        p = ptp;
        chk("trigger", 64'h1, 64'(trig));
        @(negedge clk);
        chk("pulse end", 64'h0, 64'(evt));
    endtask : wev

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, tme_pkg::OFS_CTRL, 32'h0);
        chk("ctrl", 64'h0, 64'(rd));
        apb(1'b0, 8'h3c, 32'h0);
        chk("slverr", 64'h1, 64'(err));
        chk("clock id", eui(MAC), cid);
        apb(1'b1, tme_pkg::OFS_CMD, 32'h1);
        repeat (1000) @(posedge clk);
        apb(1'b1, tme_pkg::OFS_CMD, 32'h2);
        apb(1'b0, tme_pkg::OFS_CAP_LO, 32'h0);
        chk("local count", 64'ha, 64'(rd));
        apb(1'b1, tme_pkg::OFS_CTRL, 32'h1);
        apb(1'b0, tme_pkg::OFS_STATUS, 32'h0);
        chk("source", 64'h1, 64'(rd[0]));
        chk("auto master", 64'h1, 64'(is_m));
        peer.announce(MAC + 48'h1);
        peer.announce(MAC - 48'h1);
        repeat (2) @(negedge clk);
        chk("slave", 64'h0, 64'(is_m));
        chk("master id", eui(MAC - 48'h1), mid);
        repeat (50) @(posedge clk);
        apb(1'b0, tme_pkg::OFS_STATUS, 32'h0);
        chk("elect done", 64'h1, 64'(rd[2]));
        apb(1'b1, tme_pkg::OFS_CMD, 32'h1);
        apb(1'b1, tme_pkg::OFS_CMD, 32'h2);
        apb(1'b0, tme_pkg::OFS_CAP_LO, 32'h0);
        chk("sync kept", 64'h1, 64'((ptp[31:0] - rd) < 32'h8));
        apb(1'b1, tme_pkg::OFS_PERIOD, 32'ha);
        apb(1'b1, tme_pkg::OFS_START_LO, 32'h1000);
        apb(1'b1, tme_pkg::OFS_START_HI, 32'h0);
        apb(1'b1, tme_pkg::OFS_IRQ_MASK, 32'h1);
        apb(1'b1, tme_pkg::OFS_CTRL, 32'h7);
        repeat (70) @(posedge clk);
        apb(1'b0, tme_pkg::OFS_EFF_LO, 32'h0);
        chk("eff start", 64'h1004, 64'(rd));
        wev(t1);
        chk("first", 64'h1005, t1);
        apb(1'b1, tme_pkg::OFS_CMD, 32'h1);
        wev(t2);
        chk("repeat", t1 + 64'ha, t2);
        apb(1'b1, tme_pkg::OFS_PERIOD, 32'h14);
        wev(t3);
        chk("new period", t2 + 64'h14, t3);
        chk("irq", 64'h1, 64'(irq));
        apb(1'b1, tme_pkg::OFS_CTRL, 32'h1);
        apb(1'b1, tme_pkg::OFS_IRQ_STAT, 32'h1);
        @(negedge clk);
        chk("irq clear", 64'h0, 64'(irq));
        apb(1'b1, tme_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, tme_pkg::OFS_CTRL, 32'h19);
        repeat (2) @(negedge clk);
        chk("manual", 64'h1, 64'(is_m));
        // local base: a clear before the first event keeps the target
        apb(1'b1, tme_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, tme_pkg::OFS_PERIOD, 32'h3);
        apb(1'b1, tme_pkg::OFS_START_LO, 32'h4);
        apb(1'b1, tme_pkg::OFS_CMD, 32'h1);
        apb(1'b1, tme_pkg::OFS_CTRL, 32'h6);
        repeat (450) @(posedge clk);
        apb(1'b1, tme_pkg::OFS_CMD, 32'h1);
        apb(1'b0, tme_pkg::OFS_EFF_LO, 32'h0);
        chk("eff kept", 64'h6, 64'(rd));
        wev(t1);
        apb(1'b1, tme_pkg::OFS_CMD, 32'h2);
        apb(1'b0, tme_pkg::OFS_CAP_LO, 32'h0);
        chk("kept target", 64'h6, 64'(rd));
        // a clear while running restarts at the first multiple after it
        apb(1'b1, tme_pkg::OFS_CMD, 32'h1);
        wev(t2);
        apb(1'b1, tme_pkg::OFS_CMD, 32'h2);
        apb(1'b0, tme_pkg::OFS_CAP_LO, 32'h0);
        chk("restart", 64'h3, 64'(rd));
        conclude();
    end
endmodule : tme_timestamp_modulo_tb
